/* File: pcisig_pkg.sv */
// Shared constants and types for the PCI bus signal interface ends
package pcisig_pkg;
	localparam int PCISIG_AD_W = 32;
	localparam int PCISIG_BE_W = 4;
	// Bus commands on the command/enable lanes during the address phase
	localparam logic [3:0] PCISIG_CMD_IO_RD = 4'h2;
	localparam logic [3:0] PCISIG_CMD_IO_WR = 4'h3;
	localparam logic [3:0] PCISIG_CMD_MEM_RD = 4'h6;
	localparam logic [3:0] PCISIG_CMD_MEM_WR = 4'h7;
	localparam logic [3:0] PCISIG_CMD_CFG_RD = 4'hA;
	localparam logic [3:0] PCISIG_CMD_CFG_WR = 4'hB;
	// Command bit 0 set means write for all commands above
	localparam int PCISIG_CMD_WR_BIT = 0;
	// Bus clock limit, in kHz, and the system clock rate
	localparam int PCISIG_BUS_CLK_MAX_KHZ = 33333;
	localparam int PCISIG_SYS_CLK_KHZ = 40000;
	// Target answers with DEVSEL/TRDY this many cycles after the address phase
	localparam int PCISIG_DEVSEL_DLY = 1;
	localparam logic [31:0] PCISIG_BAR_RESET = 32'h0000_0000;
	localparam logic [31:0] PCISIG_BAR_MASK = 32'hFFFF_F000;
	typedef enum logic [1:0] {PCISIG_T_IDLE, PCISIG_T_DATA, PCISIG_T_TURN} pcisig_tgt_st_t;
	typedef enum logic [2:0] {PCISIG_M_IDLE, PCISIG_M_REQ, PCISIG_M_ADDR, PCISIG_M_DATA,
		PCISIG_M_TURN} pcisig_mst_st_t;
endpackage

/* File: pcisig_bus_if.sv */
// Bus wires between the capture device end and the host end
`timescale 1ns/10ps
`default_nettype none
interface pcisig_bus_if;
	import pcisig_pkg::*;
	// Per-driver signal, output enable and resolved level for each shared line
	logic [31:0] ad_dev_o, ad_host_o, ad;
	logic ad_dev_oe_n, ad_host_oe_n;
	logic [3:0] cbe_dev_o, cbe_host_o, cbe_n;
	logic cbe_dev_oe_n, cbe_host_oe_n;
	logic par_dev_o, par_host_o, par;
	logic par_dev_oe_n, par_host_oe_n;
	logic frame_dev_o, frame_host_o, frame_n;
	logic frame_dev_oe_n, frame_host_oe_n;
	logic irdy_dev_o, irdy_host_o, irdy_n;
	logic irdy_dev_oe_n, irdy_host_oe_n;
	logic trdy_dev_o, trdy_host_o, trdy_n;
	logic trdy_dev_oe_n, trdy_host_oe_n;
	logic devsel_dev_o, devsel_host_o, devsel_n;
	logic devsel_dev_oe_n, devsel_host_oe_n;
	logic req_n, gnt_n, idsel;
	// Resolve: device wins if enabled, else host, else pulled up
	assign ad = !ad_dev_oe_n ? ad_dev_o : (!ad_host_oe_n ? ad_host_o : '1);
	assign cbe_n = !cbe_dev_oe_n ? cbe_dev_o : (!cbe_host_oe_n ? cbe_host_o : '1);
	assign par = !par_dev_oe_n ? par_dev_o : (!par_host_oe_n ? par_host_o : 1'b1);
	assign frame_n = !frame_dev_oe_n ? frame_dev_o : (!frame_host_oe_n ? frame_host_o : 1'b1);
	assign irdy_n = !irdy_dev_oe_n ? irdy_dev_o : (!irdy_host_oe_n ? irdy_host_o : 1'b1);
	assign trdy_n = !trdy_dev_oe_n ? trdy_dev_o : (!trdy_host_oe_n ? trdy_host_o : 1'b1);
	assign devsel_n = !devsel_dev_oe_n ? devsel_dev_o :
		(!devsel_host_oe_n ? devsel_host_o : 1'b1);
	modport dev (
		input ad, cbe_n, par, frame_n, irdy_n, trdy_n, devsel_n, gnt_n, idsel,
		output ad_dev_o, ad_dev_oe_n, cbe_dev_o, cbe_dev_oe_n, par_dev_o, par_dev_oe_n,
		frame_dev_o, frame_dev_oe_n, irdy_dev_o, irdy_dev_oe_n, trdy_dev_o, trdy_dev_oe_n,
		devsel_dev_o, devsel_dev_oe_n, req_n
	);
	modport host (
		input ad, cbe_n, par, frame_n, irdy_n, trdy_n, devsel_n, req_n,
		output ad_host_o, ad_host_oe_n, cbe_host_o, cbe_host_oe_n, par_host_o, par_host_oe_n,
		frame_host_o, frame_host_oe_n, irdy_host_o, irdy_host_oe_n, trdy_host_o,
		trdy_host_oe_n, devsel_host_o, devsel_host_oe_n, gnt_n, idsel
	);
endinterface
`default_nettype wire

/* File: pcisig_dev.sv */
// Capture device end: PCI target for config/IO/memory and DMA write master
// How it works
// - config access claimed only with select input high
// - one address phase, then data phases
// - address phase is first FRAME cycle
// - AD low byte least, high byte most significant
// - data valid whenever TRDY/IRDY asserted
// - word moves only when IRDY and TRDY low
// - command in address phase, enables in data
// - enables steady per phase, lane order kept
// - parity makes ones count even
// - address parity driven one clock later
// - data parity one clock after, held one
// - target drives read parity, master otherwise
// - FRAME held, dropped for the final phase
// - IRDY marks ready to accept or data placed
// - DEVSEL driven only after address decode
// - everything sampled on rising clock edge
// - reset floats all bus outputs asynchronously; req_n is driven high, not floated
`timescale 1ns/10ps
`default_nettype none
module pcisig_dev
	import pcisig_pkg::*;
#(
	parameter int AD_W = pcisig_pkg::PCISIG_AD_W
) (
	input wire logic clk_sys, // Bus clock
	input wire logic nrst, // Bus reset, async, active low
	pcisig_bus_if.dev bus, // Bus wires
	input wire logic dma_start, // Pulse: start one DMA write burst
	input wire logic [AD_W-1:0] dma_addr, // Burst start address, dword aligned
	input wire logic [7:0] dma_len, // Burst length in words, at least 1
	input wire logic [AD_W-1:0] dma_data, // Word for the current data phase
	output logic dma_data_take, // Pulse: current word was transferred
	output logic dma_busy, // Master sequence in progress
	output logic [AD_W-1:0] cap_ctrl // Control word written by the host
);
	import pcisig_pkg::*;

	// Target state
	pcisig_tgt_st_t tst_r, tst_nxt;
	logic [AD_W-1:0] bar_r, ctrl_r, rdata_r;
	logic [3:0] cmd_r;
	logic [AD_W-1:0] taddr_r;
	logic frame_q_r, tpar_oe_r, tpar_r;
	// Master state
	pcisig_mst_st_t mst_r, mst_nxt;
	logic [AD_W-1:0] maddr_r;
	logic [7:0] mleft_r;
	logic mpar_oe_r, mpar_r;

	// Limitation: no offset decode; every config hit lands on the base
	// register and every memory or IO hit on the control word
	// Decode during the address phase; idle-to-low FRAME edge marks it.
	// FRAME must have been high a clock earlier, or a later burst cycle
	// would be decoded again as an address
	wire addr_phase = !bus.frame_n && frame_q_r && tst_r == PCISIG_T_IDLE;
	wire [3:0] cmd_in = bus.cbe_n;
	wire is_cfg = cmd_in[3:1] == PCISIG_CMD_CFG_RD[3:1];
	wire is_mem = cmd_in[3:1] == PCISIG_CMD_MEM_RD[3:1];
	wire is_io = cmd_in[3:1] == PCISIG_CMD_IO_RD[3:1];
	// IO decodes the dword address, memory the 4 KiB window address
	wire hit_io = is_io && bus.ad[AD_W-1:2] == bar_r[AD_W-1:2];
	wire hit_mem = is_mem && (bus.ad & PCISIG_BAR_MASK) == bar_r;
	wire hit_cfg = is_cfg && bus.idsel;
	wire hit = addr_phase && (hit_cfg || hit_mem || hit_io) && mst_r == PCISIG_M_IDLE;
	// Command held from the address phase; the lanes carry enables after it
	wire t_wr = cmd_r[PCISIG_CMD_WR_BIT];
	wire xfer = !bus.irdy_n && !bus.trdy_n;
	wire t_xfer = tst_r == PCISIG_T_DATA && xfer;
	wire t_last = t_xfer && bus.frame_n;
	// Lane-wise write merge under active-low enables; a disabled lane keeps its old byte
	wire [AD_W-1:0] wmask;
	for (genvar i = 0; i < PCISIG_BE_W; i++) begin : g_lane
		assign wmask[i*8 +: 8] = {8{!bus.cbe_n[i]}};
	end
	wire [AD_W-1:0] wr_src = cmd_r[3:1] == PCISIG_CMD_CFG_RD[3:1] ? bar_r : ctrl_r;
	wire [AD_W-1:0] wr_val = (wr_src & ~wmask) | (bus.ad & wmask);
	wire sel_bar = cmd_r[3:1] == PCISIG_CMD_CFG_RD[3:1];
	// On the decode edge the held command is still the previous one, so the
	// read source must follow the command on the lanes instead
	wire rd_sel_bar = hit ? is_cfg : sel_bar;

	// Target sequencing
	always_comb begin
		tst_nxt = tst_r;
		unique case (tst_r)
			PCISIG_T_IDLE: if (hit) tst_nxt = PCISIG_T_DATA;
			PCISIG_T_DATA: if (t_last) tst_nxt = PCISIG_T_TURN;
			PCISIG_T_TURN: tst_nxt = PCISIG_T_IDLE;
		endcase
	end

	// Bus sampled only on rising edges; reset floats everything but req_n, which is held high
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			tst_r <= PCISIG_T_IDLE;
			frame_q_r <= 1'b1;
			cmd_r <= 4'h0;
			taddr_r <= '0;
		end else begin
			tst_r <= tst_nxt;
			frame_q_r <= bus.frame_n;
			if (hit) begin
				cmd_r <= cmd_in;
				taddr_r <= bus.ad;
			end
		end
	end

	// Target register writes and read data, merged per lane
	// Base register keeps its low bits clear, so the window stays 4 KiB aligned
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			bar_r <= PCISIG_BAR_RESET;
			ctrl_r <= '0;
		end else if (t_xfer && t_wr) begin
			if (sel_bar) bar_r <= wr_val & PCISIG_BAR_MASK;
			else ctrl_r <= wr_val;
		end
	end

	// Read data from flops; parity follows data by one clock
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rdata_r <= '0;
			tpar_r <= 1'b0;
			tpar_oe_r <= 1'b0;
		end else begin
			rdata_r <= rd_sel_bar ? bar_r : ctrl_r;
			tpar_r <= ^{bus.ad_dev_o, bus.cbe_n};
			tpar_oe_r <= tst_r == PCISIG_T_DATA && !t_wr;
		end
	end
	assign bus.ad_dev_o = mst_r == PCISIG_M_ADDR ? maddr_r : (mst_r == PCISIG_M_DATA ?
		dma_data : rdata_r);

	// Target drives AD for reads, ready on the cycle after decode.
	// Trade-off: no wait states and no disconnect, so every word is taken at once
	wire t_drive = tst_r == PCISIG_T_DATA;
	assign bus.devsel_dev_o = 1'b0;
	assign bus.devsel_dev_oe_n = !(t_drive || tst_r == PCISIG_T_TURN);
	assign bus.trdy_dev_o = !t_drive;
	assign bus.trdy_dev_oe_n = !(t_drive || tst_r == PCISIG_T_TURN);

	// Master sequencing for DMA write bursts
	// Waiting for an idle bus as well as grant keeps a late grant from
	// colliding with another master's last data phase
	wire m_xfer = mst_r == PCISIG_M_DATA && xfer;
	wire bus_idle = bus.frame_n && bus.irdy_n;
	always_comb begin
		mst_nxt = mst_r;
		unique case (mst_r)
			PCISIG_M_IDLE: if (dma_start) mst_nxt = PCISIG_M_REQ;
			PCISIG_M_REQ: if (!bus.gnt_n && bus_idle && tst_r == PCISIG_T_IDLE)
				mst_nxt = PCISIG_M_ADDR;
			PCISIG_M_ADDR: mst_nxt = PCISIG_M_DATA;
			PCISIG_M_DATA: if (m_xfer && mleft_r == 8'h01) mst_nxt = PCISIG_M_TURN;
			PCISIG_M_TURN: mst_nxt = PCISIG_M_IDLE;
		endcase
	end

	// Master counters and parity
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			mst_r <= PCISIG_M_IDLE;
			maddr_r <= '0;
			mleft_r <= 8'h00;
			mpar_r <= 1'b0;
			mpar_oe_r <= 1'b0;
		end else begin
			mst_r <= mst_nxt;
			if (mst_r == PCISIG_M_IDLE && dma_start) begin
				// Start address forced to a dword boundary
				maddr_r <= {dma_addr[AD_W-1:2], 2'b00};
				mleft_r <= dma_len;
			end
			if (m_xfer) mleft_r <= mleft_r - 8'h01;
			mpar_r <= ^{bus.ad_dev_o, bus.cbe_dev_o};
			mpar_oe_r <= mst_r == PCISIG_M_ADDR || mst_r == PCISIG_M_DATA;
		end
	end

	// Bus ownership covers the address and data phases only
	wire m_own = mst_r == PCISIG_M_ADDR || mst_r == PCISIG_M_DATA;
	// Request stays up while more than one word remains and drops for the
	// last, so the arbiter may hand the bus on straight after
	assign bus.req_n = !(mst_r == PCISIG_M_REQ || (m_own && mleft_r > 8'h01));

	// FRAME drops with the last data phase; IRDY always ready with data
	assign bus.frame_dev_o = !(mst_r == PCISIG_M_ADDR ||
		(mst_r == PCISIG_M_DATA && mleft_r != 8'h01));
	assign bus.frame_dev_oe_n = !m_own;
	assign bus.irdy_dev_o = mst_r != PCISIG_M_DATA;
	assign bus.irdy_dev_oe_n = !(mst_r == PCISIG_M_DATA || mst_r == PCISIG_M_TURN);
	// Full enables on every DMA word; partial words are not supported
	assign bus.cbe_dev_o = mst_r == PCISIG_M_ADDR ? PCISIG_CMD_MEM_WR : 4'h0;
	assign bus.cbe_dev_oe_n = !m_own;
	assign bus.ad_dev_oe_n = !(m_own || (t_drive && !t_wr));

	// Parity is enabled a clock behind its lanes; the two roles never
	// overlap because the master and target states exclude each other
	assign bus.par_dev_o = mpar_oe_r ? mpar_r : tpar_r;
	assign bus.par_dev_oe_n = !(mpar_oe_r || tpar_oe_r);

	// Plain views of state for the capture side
	assign dma_data_take = m_xfer;
	assign dma_busy = mst_r != PCISIG_M_IDLE;
	assign cap_ctrl = ctrl_r;
endmodule
`default_nettype wire

/* File: pcisig_host.sv */
// Host end: master for single accesses, arbiter, target for DMA writes
`timescale 1ns/10ps
`default_nettype none
module pcisig_host
	import pcisig_pkg::*;
(
	input wire logic clk_sys, // Bus clock
	input wire logic nrst, // Bus reset, async, active low
	pcisig_bus_if.host bus, // Bus wires
	input wire logic acc_start, // Pulse: start a single-word access
	input wire logic [3:0] acc_cmd, // Bus command
	input wire logic [31:0] acc_addr, // Address
	input wire logic [3:0] acc_be_n, // Active-low byte enables
	input wire logic [31:0] acc_wdata, // Write data
	input wire logic acc_idsel, // Select line for config accesses
	output logic acc_busy, // Access in progress
	output logic acc_done, // Pulse: access finished
	output logic [31:0] acc_rdata, // Read data, held after done
	output logic acc_noresp, // Last access saw no DEVSEL
	output logic dma_wr_valid, // Pulse: word received from device
	output logic [31:0] dma_wr_addr, // Its address
	output logic [31:0] dma_wr_data // Its data
);
	import pcisig_pkg::*;

	localparam logic [3:0] TIMEOUT = 4'h6;
	pcisig_mst_st_t st_r, st_nxt;
	logic [3:0] cmd_r, be_r, wait_r;
	logic [31:0] addr_r, wdata_r, rdata_r, daddr_r, ddata_r;
	logic idsel_r, par_r, par_oe_r, done_r, nores_r, dval_r, tgt_r, tturn_r;

	wire xfer = !bus.irdy_n && !bus.trdy_n;
	wire is_wr = cmd_r[PCISIG_CMD_WR_BIT];
	wire give_up = wait_r == TIMEOUT && bus.devsel_n;
	wire fin = st_r == PCISIG_M_DATA && (xfer || give_up);
	always_comb begin
		st_nxt = st_r;
		unique case (st_r)
			PCISIG_M_IDLE: if (acc_start) st_nxt = PCISIG_M_REQ;
			PCISIG_M_REQ: if (bus.req_n && bus.frame_n && bus.irdy_n)
				st_nxt = PCISIG_M_ADDR;
			PCISIG_M_ADDR: st_nxt = PCISIG_M_DATA;
			PCISIG_M_DATA: if (fin) st_nxt = PCISIG_M_TURN;
			PCISIG_M_TURN: st_nxt = PCISIG_M_IDLE;
		endcase
	end

	// Master side of single accesses
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			st_r <= PCISIG_M_IDLE;
			{cmd_r, be_r, wait_r} <= '0;
			{addr_r, wdata_r, rdata_r} <= '0;
			{idsel_r, par_r, par_oe_r, done_r, nores_r} <= '0;
		end else begin
			st_r <= st_nxt;
			if (st_r == PCISIG_M_IDLE && acc_start) begin
				cmd_r <= acc_cmd;
				be_r <= acc_be_n;
				addr_r <= acc_addr;
				wdata_r <= acc_wdata;
				idsel_r <= acc_idsel;
			end
			wait_r <= st_r == PCISIG_M_DATA ? wait_r + 4'h1 : 4'h0;
			if (st_r == PCISIG_M_DATA && xfer && !is_wr) rdata_r <= bus.ad;
			par_r <= ^{bus.ad_host_o, bus.cbe_host_o};
			par_oe_r <= st_r == PCISIG_M_ADDR || (st_r == PCISIG_M_DATA && is_wr);
			done_r <= fin;
			if (fin) nores_r <= !xfer;
		end
	end
	wire own = st_r == PCISIG_M_ADDR || st_r == PCISIG_M_DATA;
	// Host target for device DMA: claim every memory write, one wait-free word each
	// Request is no guide here: a one-word burst has already dropped it
	wire dev_addr = !bus.frame_n && bus.irdy_n && !tgt_r && !own;
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			{tgt_r, tturn_r, dval_r} <= '0;
			{daddr_r, ddata_r} <= '0;
		end else begin
			tturn_r <= tgt_r && xfer && bus.frame_n;
			dval_r <= tgt_r && xfer;
			if (dev_addr && bus.cbe_n == PCISIG_CMD_MEM_WR) begin
				tgt_r <= 1'b1;
				daddr_r <= bus.ad;
			end else if (tgt_r && xfer) begin
				ddata_r <= bus.ad;
				daddr_r <= daddr_r + 32'h0000_0004;
				if (bus.frame_n) tgt_r <= 1'b0;
			end
		end
	end
	assign bus.ad_host_o = st_r == PCISIG_M_ADDR ? addr_r : wdata_r;
	assign bus.ad_host_oe_n = !(st_r == PCISIG_M_ADDR || (st_r == PCISIG_M_DATA && is_wr));
	assign bus.cbe_host_o = st_r == PCISIG_M_ADDR ? cmd_r : be_r;
	assign bus.cbe_host_oe_n = !own;
	assign bus.par_host_o = par_r;
	assign bus.par_host_oe_n = !par_oe_r;
	assign bus.frame_host_o = st_r != PCISIG_M_ADDR;
	assign bus.frame_host_oe_n = !own;
	assign bus.irdy_host_o = st_r != PCISIG_M_DATA;
	assign bus.irdy_host_oe_n = !(st_r == PCISIG_M_DATA || st_r == PCISIG_M_TURN);
	assign bus.trdy_host_o = !tgt_r;
	assign bus.trdy_host_oe_n = !(tgt_r || tturn_r);
	assign bus.devsel_host_o = !tgt_r;
	assign bus.devsel_host_oe_n = !(tgt_r || tturn_r);
	assign bus.idsel = st_r == PCISIG_M_ADDR && idsel_r;
	// Arbiter: device granted whenever it asks and the host is neither requesting nor mastering
	assign bus.gnt_n = !(!bus.req_n && st_r != PCISIG_M_ADDR && st_r != PCISIG_M_DATA &&
		st_r != PCISIG_M_REQ);
	assign acc_busy = st_r != PCISIG_M_IDLE;
	assign acc_done = done_r;
	assign acc_rdata = rdata_r;
	assign acc_noresp = nores_r;
	assign dma_wr_valid = dval_r;
	assign dma_wr_addr = daddr_r - 32'h0000_0004;
	assign dma_wr_data = ddata_r;
endmodule
`default_nettype wire

/* File: pcisig_monitor.sv */
// Concurrent checks on the shared wires between the device end and the host end
`timescale 1ns/10ps
`default_nettype none
module pcisig_monitor
	import pcisig_pkg::*;
(
	input wire logic clk_sys, // Bus clock
	input wire logic nrst, // Bus reset, active low
	input wire logic [31:0] ad, // Resolved address/data
	input wire logic [3:0] cbe_n, // Resolved command/enables
	input wire logic par, // Resolved parity
	input wire logic frame_n, // Resolved frame
	input wire logic irdy_n, // Resolved initiator ready
	input wire logic trdy_n, // Resolved target ready
	input wire logic devsel_n, // Resolved device select
	input wire logic req_n, // Device request
	input wire logic gnt_n, // Device grant
	input wire logic idsel, // Config select
	input wire logic frame_dev_oe_n // Device frame enable
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	// Parity trails its lanes by one clock, so it is compared with last cycle's lanes
	addr_parity_a: assert property ($fell(frame_n) |=> !(par ^ ^$past(ad) ^ ^$past(cbe_n)))
		else $error("address parity wrong");
	data_parity_a: assert property (!irdy_n && !trdy_n |=> !(par ^ ^$past(ad) ^ ^$past(cbe_n)))
		else $error("data parity wrong");
	// Framing: no ready in the address phase, ready held into the last phase
	addr_phase_a: assert property ($fell(frame_n) |-> irdy_n && trdy_n)
		else $error("ready seen in address phase");
	last_phase_a: assert property ($rose(frame_n) |-> !irdy_n)
		else $error("frame dropped without ready");
	end_release_a: assert property (!irdy_n && !trdy_n && frame_n |=> irdy_n)
		else $error("ready kept after last transfer");
	// Claiming only follows a decoded address phase; the device starts a burst only when granted
	devsel_decode_a: assert property ($fell(devsel_n) |-> !$past(frame_n))
		else $error("select without address phase");
	cfg_select_a: assert property ($fell(frame_n) && cbe_n[3:1] == PCISIG_CMD_CFG_RD[3:1] && !idsel
		|=> devsel_n[*2])
		else $error("config claimed without select");
	grant_start_a: assert property ($fell(frame_n) && !frame_dev_oe_n |-> !$past(gnt_n) && !$past(req_n))
		else $error("device started without grant");
	// Wait states inside a data phase must not disturb the enables
	enable_steady_a: assert property (!irdy_n && trdy_n ##1 !irdy_n |-> $stable(cbe_n))
		else $error("enables moved in wait");
endmodule
`default_nettype wire

/* File: tb_pci_bus_signal_interface.sv */
// Self-checking bench joining the device end to the host end
`timescale 1ns/10ps
`default_nettype none
module tb_pci_bus_signal_interface;
	import pcisig_pkg::*;
	typedef struct packed {
		logic [3:0] cmd; logic [31:0] addr; logic [3:0] be_n; logic [31:0] wdata;
		logic sel; logic noresp; logic [31:0] rdata;
	} pcisig_row_t;
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	logic acc_start = 1'b0, acc_idsel = 1'b0, dma_start = 1'b0;
	logic [3:0] acc_cmd = 4'h0, acc_be_n = 4'h0;
	logic [31:0] acc_addr = 32'h0000_0000, acc_wdata = 32'h0000_0000, dma_addr = 32'h0000_8000;
	logic [7:0] dma_len = 8'h01;
	logic [31:0] dma_data, acc_rdata, dma_wr_addr, dma_wr_data, cap_ctrl;
	logic acc_busy, acc_done, acc_noresp, dma_wr_valid, dma_data_take, dma_busy;
	int fail_count = 0, tests_run = 0, cycles = 0, widx = 0;
	logic [31:0] got_addr [$];
	logic [31:0] got_data [$];
	logic [7:0] lens [3] = '{8'h01, 8'h04, 8'h08};
	pcisig_row_t rows [9];
	pcisig_row_t r;
	assign dma_data = 32'hD000_0000 + 32'(widx);
	pcisig_bus_if u_bus ();
	pcisig_dev u_pcisig_dev (.clk_sys(clk_sys), .nrst(nrst), .bus(u_bus), .dma_start(dma_start),
		.dma_addr(dma_addr), .dma_len(dma_len), .dma_data(dma_data), .dma_data_take(dma_data_take),
		.dma_busy(dma_busy), .cap_ctrl(cap_ctrl));
	pcisig_host u_pcisig_host (.clk_sys(clk_sys), .nrst(nrst), .bus(u_bus), .acc_start(acc_start),
		.acc_cmd(acc_cmd), .acc_addr(acc_addr), .acc_be_n(acc_be_n), .acc_wdata(acc_wdata),
		.acc_idsel(acc_idsel), .acc_busy(acc_busy), .acc_done(acc_done), .acc_rdata(acc_rdata),
		.acc_noresp(acc_noresp), .dma_wr_valid(dma_wr_valid), .dma_wr_addr(dma_wr_addr),
		.dma_wr_data(dma_wr_data));
	pcisig_monitor u_pcisig_monitor (.clk_sys(clk_sys), .nrst(nrst), .ad(u_bus.ad),
		.cbe_n(u_bus.cbe_n), .par(u_bus.par), .frame_n(u_bus.frame_n), .irdy_n(u_bus.irdy_n),
		.trdy_n(u_bus.trdy_n), .devsel_n(u_bus.devsel_n), .req_n(u_bus.req_n),
		.gnt_n(u_bus.gnt_n), .idsel(u_bus.idsel), .frame_dev_oe_n(u_bus.frame_dev_oe_n));
	// 40 MHz clock
	initial begin
		forever #12.5 clk_sys = ~clk_sys;
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic give_verdict();
		if (fail_count == 0 && tests_run > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// One host access; inputs stay put until done so the wire checks can use them
	task automatic run_acc(input pcisig_row_t a);
		int n;
		@(negedge clk_sys);
		{acc_cmd, acc_addr, acc_be_n, acc_wdata, acc_idsel} = {a.cmd, a.addr, a.be_n, a.wdata, a.sel};
		acc_start = 1'b1;
		@(negedge clk_sys);
		acc_start = 1'b0;
		check("busy", {31'h0, acc_busy}, 32'h0000_0001);
		for (n = 0; n < 40 && acc_done !== 1'b1; n++) @(negedge clk_sys);
		check("done", {31'h0, acc_done}, 32'h0000_0001);
		check("noresp", {31'h0, acc_noresp}, {31'h0, a.noresp});
		if (!a.noresp && !a.cmd[0]) check("rdata", acc_rdata, a.rdata);
	endtask
	// All device drivers floated and request idle
	task automatic check_float();
		check("float", {24'h0, u_bus.ad_dev_oe_n, u_bus.cbe_dev_oe_n, u_bus.par_dev_oe_n,
			u_bus.frame_dev_oe_n, u_bus.irdy_dev_oe_n, u_bus.trdy_dev_oe_n,
			u_bus.devsel_dev_oe_n, u_bus.req_n}, 32'h0000_00FF);
	endtask
	// Burst capture, data advance, wire checks of host phases, and the hang limit
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (dma_data_take) widx <= widx + 1;
		if (dma_wr_valid) begin
			got_addr.push_back(dma_wr_addr);
			got_data.push_back(dma_wr_data);
		end
		if (!u_bus.frame_host_oe_n && $fell(u_bus.frame_n)) begin
			check("cmd lanes", {28'h0, u_bus.cbe_n}, {28'h0, acc_cmd});
			check("addr lanes", u_bus.ad, acc_addr);
		end
		if (!u_bus.irdy_host_oe_n && !u_bus.irdy_n && !u_bus.trdy_n) begin
			check("be lanes", {28'h0, u_bus.cbe_n}, {28'h0, acc_be_n});
			if (acc_cmd[0]) check("wdata lanes", u_bus.ad, acc_wdata);
		end
		if (cycles == 3000) begin
			fail_count++;
			give_verdict();
		end
	end
	initial begin
		rows[0] = '{PCISIG_CMD_CFG_WR, 32'h0000_0010, 4'h0, 32'h1234_5ABC, 1'b1, 1'b0, 32'h0};
		rows[1] = '{PCISIG_CMD_CFG_RD, 32'h0000_0010, 4'h0, 32'h0, 1'b1, 1'b0, 32'h1234_5000};
		rows[2] = '{PCISIG_CMD_CFG_RD, 32'h0000_0010, 4'h0, 32'h0, 1'b0, 1'b1, 32'h0};
		rows[3] = '{PCISIG_CMD_MEM_WR, 32'h1234_5008, 4'h0, 32'hCAFE_0001, 1'b0, 1'b0, 32'h0};
		rows[4] = '{PCISIG_CMD_MEM_RD, 32'h1234_5FFC, 4'h0, 32'h0, 1'b0, 1'b0, 32'hCAFE_0001};
		rows[5] = '{PCISIG_CMD_IO_WR, 32'h1234_5003, 4'h0, 32'h0000_00A5, 1'b0, 1'b0, 32'h0};
		rows[6] = '{PCISIG_CMD_MEM_WR, 32'h1234_5000, 4'hD, 32'h0000_7700, 1'b0, 1'b0, 32'h0};
		rows[7] = '{PCISIG_CMD_IO_RD, 32'h1234_5001, 4'h0, 32'h0, 1'b0, 1'b0, 32'h0000_77A5};
		rows[8] = '{PCISIG_CMD_MEM_RD, 32'h1234_6000, 4'h0, 32'h0, 1'b0, 1'b1, 32'h0};
		repeat (3) @(posedge clk_sys);
		check_float();
		@(negedge clk_sys);
		nrst = 1'b1;
		foreach (rows[i]) run_acc(rows[i]);
		check("ctrl", cap_ctrl, 32'h0000_77A5);
		// Config read after an unclaimed memory read, IO read still held as command: the read source must follow the new command
		run_acc(rows[1]);
		// Bursts; the second has a host access queued behind it, the third is cut by reset
		foreach (lens[k]) begin
			got_addr.delete();
			got_data.delete();
			@(negedge clk_sys);
			widx = 0;
			dma_len = lens[k];
			dma_start = 1'b1;
			@(negedge clk_sys);
			dma_start = 1'b0;
			if (k == 1) run_acc(rows[7]);
			if (k == 2) break;
			for (int n = 0; n < 60 && dma_busy !== 1'b0; n++) @(negedge clk_sys);
			repeat (2) @(negedge clk_sys);
			check("dma idle", {31'h0, dma_busy}, 32'h0000_0000);
			check("burst count", 32'(got_addr.size()), {24'h0, lens[k]});
			foreach (got_addr[j]) begin
				check("burst addr", got_addr[j], dma_addr + 32'(4 * j));
				check("burst data", got_data[j], 32'hD000_0000 + 32'(j));
			end
		end
		repeat (3) @(negedge clk_sys);
		nrst = 1'b0;
		#1;
		check_float();
		repeat (3) @(negedge clk_sys);
		nrst = 1'b1;
		r = rows[1];
		r.rdata = PCISIG_BAR_RESET;
		run_acc(r);
		give_verdict();
	end
endmodule
`default_nettype wire
